// >>> design/spmpm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
`default_nettype none
module spmpm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("spmpm_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule : spmpm_fifo
`default_nettype wire

// >>> design/spmpm_pkg.sv
// Constants shared by the serial master and port mux block.
// Assumes an 8-bit special register bus with byte addresses.
package spmpm_pkg;
    localparam logic [7:0] ADDR_PORT_A_DATA = 8'h80;
    localparam logic [7:0] ADDR_SERIAL_PIN_DATA = 8'h90;
    localparam logic [7:0] ADDR_PORT_A_DRIVE = 8'h93;
    localparam logic [7:0] ADDR_PORT_A_DIR = 8'h94;
    localparam logic [7:0] ADDR_PORT_A_ALT = 8'h95;
    localparam logic [7:0] ADDR_SERIAL_PIN_DIR = 8'h96;
    localparam logic [7:0] ADDR_SERIAL_PIN_ALT = 8'h97;
    localparam logic [7:0] ADDR_RADIO_SELECT = 8'hA0;
    localparam logic [7:0] ADDR_SHIFT_BUFFER = 8'hB2;
    localparam logic [7:0] ADDR_ROUTE_CTRL = 8'hB3;
    localparam logic [7:0] ADDR_CLOCK_DIV = 8'hB4;

    localparam logic [7:0] RST_PORT_A_DATA = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIR = 8'h00;
    localparam logic [7:0] RST_PORT_A_DRIVE = 8'h00;
    localparam logic [7:0] RST_PORT_A_ALT = 8'h00;
    localparam logic [3:0] RST_SERIAL_PIN_DATA = 4'h0;
    localparam logic [3:0] RST_SERIAL_PIN_DIR = 4'h0;
    localparam logic [3:0] RST_SERIAL_PIN_ALT = 4'h7;
    localparam logic [7:0] RST_RADIO_SELECT = 8'hFF;
    localparam logic [7:0] RST_CLOCK_DIV = 8'h03;
    localparam logic RST_BOOT_SELECT = 1'b1;

    localparam int ROUTE_RADIO_BIT = 0;
    localparam int ROUTE_BOOT_SEL_BIT = 1;
    localparam int ROUTE_LOADER_REQ_BIT = 2;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_RX_AVAIL_BIT = 5;
    localparam int STAT_RX_FULL_BIT = 6;

    localparam int SCK_PIN = 0;
    localparam int MOSI_PIN = 1;
    localparam int MISO_PIN = 2;

    localparam logic [7:0] CLOCK_DIV_MIN = 8'h03;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int RX_FIFO_DEPTH = 8;
    localparam int DATA_W = 8;
endpackage : spmpm_pkg

// >>> design/spmpm_shifter.sv
// Link-domain byte shifter, mode 0, most significant bit first.
// Assumes the request toggle and its byte and divider stay put until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module spmpm_shifter (
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic req_tgl,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] clock_div,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic ack_tgl,
    output logic [7:0] rx_byte
);
    typedef enum logic {SPMPM_IDLE, SPMPM_SHIFT} spmpm_shift_state_t;

    spmpm_shift_state_t state_ff;
    logic req_s1_ff;
    logic req_s2_ff;
    logic miso_s1_ff;
    logic miso_s2_ff;
    logic [7:0] shreg_ff;
    logic [7:0] half_ff;
    logic [7:0] cnt_ff;
    logic [2:0] bit_ff;
    logic sck_ff;
    logic mosi_ff;
    logic ack_ff;
    logic [7:0] rx_ff;

    assign sck = sck_ff;
    assign mosi = mosi_ff;
    assign ack_tgl = ack_ff;
    assign rx_byte = rx_ff;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
        end else begin
            req_s1_ff <= req_tgl;
            req_s2_ff <= req_s1_ff;
            miso_s1_ff <= miso;
            miso_s2_ff <= miso_s1_ff;
        end
    end

    // Sampling at the end of the high phase leaves the long round trip time to settle
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SPMPM_IDLE;
            shreg_ff <= 8'h00;
            half_ff <= spmpm_pkg::CLOCK_DIV_MIN;
            cnt_ff <= 8'h00;
            bit_ff <= 3'h0;
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
            ack_ff <= 1'b0;
            rx_ff <= 8'h00;
        end else begin
            case (state_ff)
                SPMPM_IDLE: begin
                    if (req_s2_ff != ack_ff) begin
                        shreg_ff <= tx_byte;
                        mosi_ff <= tx_byte[7];
                        half_ff <= (clock_div < spmpm_pkg::CLOCK_DIV_MIN) ?
                                   spmpm_pkg::CLOCK_DIV_MIN : clock_div;
                        cnt_ff <= 8'h00;
                        bit_ff <= 3'h0;
                        sck_ff <= 1'b0;
                        state_ff <= SPMPM_SHIFT;
                    end
                end
                SPMPM_SHIFT: begin
                    if (cnt_ff == half_ff) begin
                        cnt_ff <= 8'h00;
                        if (!sck_ff) begin
                            sck_ff <= 1'b1;
                        end else begin
                            sck_ff <= 1'b0;
                            shreg_ff <= {shreg_ff[6:0], miso_s2_ff};
                            mosi_ff <= shreg_ff[6];
                            bit_ff <= bit_ff + 1'b1;
                            if (bit_ff == spmpm_pkg::LAST_BIT) begin
                                rx_ff <= {shreg_ff[6:0], miso_s2_ff};
                                ack_ff <= ~ack_ff;
                                mosi_ff <= 1'b0;
                                state_ff <= SPMPM_IDLE;
                            end
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: begin
                    state_ff <= SPMPM_IDLE;
                end
            endcase
        end
    end
endmodule : spmpm_shifter
`default_nettype wire

// >>> design/spmpm_top.sv
// Serial master with port logic: registers, pin muxing, link crossing, receive FIFO.
// Assumes a special register bus on clk; the shifter runs on link_clk.
//
// Contract
// - Single buffer: one transfer at a time.
// - Route register switches pins or radio path.
// - Master drives no slave select itself.
// - Dedicated boot memory select output exists.
// - Radio selects come from radio select port.
// - Boot pins: MISO 2, MOSI 1, SCK 0.
// - Serial pins reusable as GPIO afterward.
// - Loader starts after reset or on request.
// - General port has eight bidirectional pins.
// - Serial pins double as second port.
// - Port pins carry alternate functions.
// - Per-pin high drive programmable on port.
// - Master raises its own interrupt request.
// - Port data registers at 0x80/0x90/0xA0.
`timescale 1ns/1ps
`default_nettype none
module spmpm_top #(
    parameter int FIFO_DEPTH = spmpm_pkg::RX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_a_drive_high,
    input wire logic [7:0] port_a_alt_in,
    output logic [7:0] port_a_pin_level,
    input wire logic [3:0] serial_pin_in,
    output logic [3:0] serial_pin_out,
    output logic [3:0] serial_pin_oe,
    output logic boot_memory_select,
    output logic [7:0] radio_select,
    output logic radio_sck,
    output logic radio_mosi,
    input wire logic radio_miso,
    output logic loader_start,
    output logic spi_irq
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("spmpm_top: receive FIFO depth must be at least 2");
        end
    end

    logic [7:0] port_a_data_ff;
    logic [7:0] port_a_dir_ff;
    logic [7:0] port_a_drive_ff;
    logic [7:0] port_a_alt_ff;
    logic [3:0] sp_data_ff;
    logic [3:0] sp_dir_ff;
    logic [3:0] sp_alt_ff;
    logic [7:0] radio_sel_reg_ff;
    logic route_radio_ff;
    logic boot_sel_ff;
    logic [7:0] clock_div_ff;
    logic [7:0] tx_byte_ff;
    logic req_tgl_ff;
    logic busy_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic loader_pending_ff;
    logic loader_start_ff;
    logic [7:0] sfr_rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] pa_in_s1_ff;
    logic [7:0] pa_in_s2_ff;
    logic [3:0] sp_in_s1_ff;
    logic [3:0] sp_in_s2_ff;
    logic rmiso_s1_ff;
    logic rmiso_s2_ff;
    logic sck_s1_ff;
    logic sck_s2_ff;
    logic mosi_s1_ff;
    logic mosi_s2_ff;
    logic miso_sel_ff;
    logic [7:0] port_a_out_ff;
    logic [7:0] port_a_oe_ff;
    logic [7:0] port_a_level_ff;
    logic [3:0] sp_out_ff;
    logic [3:0] sp_oe_ff;
    logic [7:0] radio_select_ff;
    logic radio_sck_ff;
    logic radio_mosi_ff;
    logic spi_irq_ff;
    logic link_sck;
    logic link_mosi;
    logic link_ack;
    logic [7:0] link_rx;
    logic xfer_done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic wr_shift;
    logic start_xfer;
    logic [7:0] status;

    assign sfr_rdata = sfr_rdata_ff;
    assign port_a_out = port_a_out_ff;
    assign port_a_oe = port_a_oe_ff;
    assign port_a_drive_high = port_a_drive_ff;
    assign port_a_pin_level = port_a_level_ff;
    assign serial_pin_out = sp_out_ff;
    assign serial_pin_oe = sp_oe_ff;
    assign boot_memory_select = boot_sel_ff;
    assign radio_select = radio_select_ff;
    assign radio_sck = radio_sck_ff;
    assign radio_mosi = radio_mosi_ff;
    assign loader_start = loader_start_ff;
    assign spi_irq = spi_irq_ff;

    assign wr_shift = sfr_wr && (sfr_addr == spmpm_pkg::ADDR_SHIFT_BUFFER);
    // A full receive FIFO blocks new transfers, dropping the shift buffer write, rather than losing a received byte
    assign start_xfer = wr_shift && !busy_ff && fifo_in_ready;
    assign xfer_done = busy_ff && (ack_s2_ff == req_tgl_ff);
    assign fifo_pop = sfr_rd && (sfr_addr == spmpm_pkg::ADDR_SHIFT_BUFFER);

    always_comb begin
        status = 8'h00;
        status[spmpm_pkg::ROUTE_RADIO_BIT] = route_radio_ff;
        status[spmpm_pkg::ROUTE_BOOT_SEL_BIT] = boot_sel_ff;
        status[spmpm_pkg::STAT_BUSY_BIT] = busy_ff;
        status[spmpm_pkg::STAT_RX_AVAIL_BIT] = fifo_out_valid;
        status[spmpm_pkg::STAT_RX_FULL_BIT] = !fifo_in_ready;
    end

    // Register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_a_data_ff <= spmpm_pkg::RST_PORT_A_DATA;
            port_a_dir_ff <= spmpm_pkg::RST_PORT_A_DIR;
            port_a_drive_ff <= spmpm_pkg::RST_PORT_A_DRIVE;
            port_a_alt_ff <= spmpm_pkg::RST_PORT_A_ALT;
            sp_data_ff <= spmpm_pkg::RST_SERIAL_PIN_DATA;
            sp_dir_ff <= spmpm_pkg::RST_SERIAL_PIN_DIR;
            sp_alt_ff <= spmpm_pkg::RST_SERIAL_PIN_ALT;
            radio_sel_reg_ff <= spmpm_pkg::RST_RADIO_SELECT;
            route_radio_ff <= 1'b0;
            boot_sel_ff <= spmpm_pkg::RST_BOOT_SELECT;
            clock_div_ff <= spmpm_pkg::RST_CLOCK_DIV;
        end else if (sfr_wr) begin
            if (sfr_addr == spmpm_pkg::ADDR_PORT_A_DATA) begin
                port_a_data_ff <= sfr_wdata;
            end else if (sfr_addr == spmpm_pkg::ADDR_SERIAL_PIN_DATA) begin
                sp_data_ff <= sfr_wdata[3:0];
            end else if (sfr_addr == spmpm_pkg::ADDR_RADIO_SELECT) begin
                radio_sel_reg_ff <= sfr_wdata;
            end else if (sfr_addr == spmpm_pkg::ADDR_PORT_A_DRIVE) begin
                port_a_drive_ff <= sfr_wdata;
            end else if (sfr_addr == spmpm_pkg::ADDR_PORT_A_DIR) begin
                port_a_dir_ff <= sfr_wdata;
            end else if (sfr_addr == spmpm_pkg::ADDR_PORT_A_ALT) begin
                port_a_alt_ff <= sfr_wdata;
            end else if (sfr_addr == spmpm_pkg::ADDR_SERIAL_PIN_DIR) begin
                sp_dir_ff <= sfr_wdata[3:0];
            end else if (sfr_addr == spmpm_pkg::ADDR_SERIAL_PIN_ALT) begin
                sp_alt_ff <= sfr_wdata[3:0];
            end else if (sfr_addr == spmpm_pkg::ADDR_ROUTE_CTRL) begin
                // Switching mid-transfer would glitch SCK on both paths
                if (!busy_ff) begin
                    route_radio_ff <= sfr_wdata[spmpm_pkg::ROUTE_RADIO_BIT];
                end
                boot_sel_ff <= sfr_wdata[spmpm_pkg::ROUTE_BOOT_SEL_BIT];
            end else if (sfr_addr == spmpm_pkg::ADDR_CLOCK_DIV) begin
                if (!busy_ff) begin
                    clock_div_ff <= sfr_wdata;
                end
            end
        end
    end

    // Transfer request toward the link domain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_byte_ff <= 8'h00;
            req_tgl_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            if (start_xfer) begin
                tx_byte_ff <= sfr_wdata;
                req_tgl_ff <= ~req_tgl_ff;
                busy_ff <= 1'b1;
            end else if (xfer_done) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // Acknowledge and link pin levels coming back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
        end else begin
            ack_s1_ff <= link_ack;
            ack_s2_ff <= ack_s1_ff;
            sck_s1_ff <= link_sck;
            sck_s2_ff <= sck_s1_ff;
            mosi_s1_ff <= link_mosi;
            mosi_s2_ff <= mosi_s1_ff;
        end
    end

    // Pin input synchronisers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_in_s1_ff <= 8'h00;
            pa_in_s2_ff <= 8'h00;
            sp_in_s1_ff <= 4'h0;
            sp_in_s2_ff <= 4'h0;
            rmiso_s1_ff <= 1'b0;
            rmiso_s2_ff <= 1'b0;
        end else begin
            pa_in_s1_ff <= port_a_in;
            pa_in_s2_ff <= pa_in_s1_ff;
            sp_in_s1_ff <= serial_pin_in;
            sp_in_s2_ff <= sp_in_s1_ff;
            rmiso_s1_ff <= radio_miso;
            rmiso_s2_ff <= rmiso_s1_ff;
        end
    end

    // General port: alternate functions take the output data when selected; direction stays with the register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_a_out_ff <= 8'h00;
            port_a_oe_ff <= 8'h00;
            port_a_level_ff <= 8'h00;
        end else begin
            port_a_out_ff <= (port_a_alt_ff & port_a_alt_in) |
                             (~port_a_alt_ff & port_a_data_ff);
            port_a_oe_ff <= port_a_dir_ff;
            port_a_level_ff <= pa_in_s2_ff;
        end
    end

    // Serial pins: SPI function when alternate set and routed to pins, else GPIO
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_out_ff <= 4'h0;
            sp_oe_ff <= 4'h0;
            miso_sel_ff <= 1'b0;
        end else begin
            sp_out_ff <= sp_data_ff;
            sp_oe_ff <= sp_dir_ff;
            if (sp_alt_ff[spmpm_pkg::SCK_PIN] && !route_radio_ff) begin
                sp_out_ff[spmpm_pkg::SCK_PIN] <= sck_s2_ff;
                sp_oe_ff[spmpm_pkg::SCK_PIN] <= 1'b1;
            end
            if (sp_alt_ff[spmpm_pkg::MOSI_PIN] && !route_radio_ff) begin
                sp_out_ff[spmpm_pkg::MOSI_PIN] <= mosi_s2_ff;
                sp_oe_ff[spmpm_pkg::MOSI_PIN] <= 1'b1;
            end
            if (sp_alt_ff[spmpm_pkg::MISO_PIN] && !route_radio_ff) begin
                sp_oe_ff[spmpm_pkg::MISO_PIN] <= 1'b0;
            end
            miso_sel_ff <= route_radio_ff ? rmiso_s2_ff :
                           sp_in_s2_ff[spmpm_pkg::MISO_PIN];
        end
    end

    // Internal radio path and its select port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            radio_sck_ff <= 1'b0;
            radio_mosi_ff <= 1'b0;
            radio_select_ff <= spmpm_pkg::RST_RADIO_SELECT;
        end else begin
            radio_sck_ff <= route_radio_ff && sck_s2_ff;
            radio_mosi_ff <= route_radio_ff && mosi_s2_ff;
            radio_select_ff <= route_radio_ff ? radio_sel_reg_ff :
                               spmpm_pkg::RST_RADIO_SELECT;
        end
    end

    // Loader kick: once after reset release, then on software request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loader_pending_ff <= 1'b1;
            loader_start_ff <= 1'b0;
        end else begin
            loader_pending_ff <= 1'b0;
            loader_start_ff <= loader_pending_ff ||
                               (sfr_wr && (sfr_addr == spmpm_pkg::ADDR_ROUTE_CTRL) &&
                                sfr_wdata[spmpm_pkg::ROUTE_LOADER_REQ_BIT]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            spi_irq_ff <= 1'b0;
        end else begin
            spi_irq_ff <= fifo_out_valid;
        end
    end

    // Read data; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (sfr_addr == spmpm_pkg::ADDR_PORT_A_DATA) begin
            nxt_rdata = pa_in_s2_ff;
        end else if (sfr_addr == spmpm_pkg::ADDR_SERIAL_PIN_DATA) begin
            nxt_rdata = {4'h0, sp_in_s2_ff};
        end else if (sfr_addr == spmpm_pkg::ADDR_RADIO_SELECT) begin
            nxt_rdata = radio_sel_reg_ff;
        end else if (sfr_addr == spmpm_pkg::ADDR_PORT_A_DRIVE) begin
            nxt_rdata = port_a_drive_ff;
        end else if (sfr_addr == spmpm_pkg::ADDR_PORT_A_DIR) begin
            nxt_rdata = port_a_dir_ff;
        end else if (sfr_addr == spmpm_pkg::ADDR_PORT_A_ALT) begin
            nxt_rdata = port_a_alt_ff;
        end else if (sfr_addr == spmpm_pkg::ADDR_SERIAL_PIN_DIR) begin
            nxt_rdata = {4'h0, sp_dir_ff};
        end else if (sfr_addr == spmpm_pkg::ADDR_SERIAL_PIN_ALT) begin
            nxt_rdata = {4'h0, sp_alt_ff};
        end else if (sfr_addr == spmpm_pkg::ADDR_SHIFT_BUFFER) begin
            nxt_rdata = fifo_out_valid ? fifo_out_data : 8'h00;
        end else if (sfr_addr == spmpm_pkg::ADDR_ROUTE_CTRL) begin
            nxt_rdata = status;
        end else if (sfr_addr == spmpm_pkg::ADDR_CLOCK_DIV) begin
            nxt_rdata = clock_div_ff;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_ff <= nxt_rdata;
        end
    end

    spmpm_fifo #(
        .WIDTH(spmpm_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(xfer_done),
        .in_ready(fifo_in_ready),
        .in_data(link_rx),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    spmpm_shifter u_shifter (
        .link_clk(link_clk),
        .arst_n(arst_n),
        .req_tgl(req_tgl_ff),
        .tx_byte(tx_byte_ff),
        .clock_div(clock_div_ff),
        .miso(miso_sel_ff),
        .sck(link_sck),
        .mosi(link_mosi),
        .ack_tgl(link_ack),
        .rx_byte(link_rx)
    );
endmodule : spmpm_top
`default_nettype wire

// >>> test/spmpm_monitor.sv
// Assertions on the ports of spmpm_top.
// Bound into every spmpm_top instance, clk domain only.
`timescale 1ns/1ps
`default_nettype none
module spmpm_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] port_a_drive_high,
    input wire logic boot_memory_select,
    input wire logic loader_start,
    input wire logic spi_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rd_unmapped: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    a_boot_sel: assert property (sfr_wr && sfr_addr == 8'hB3 |->
        ##2 boot_memory_select == $past(sfr_wdata[1], 2)) else $error("boot select lost");
    a_loader_req: assert property (sfr_wr && sfr_addr == 8'hB3 && sfr_wdata[2] |=>
        loader_start) else $error("loader request lost");
    // Reset release must start the loader without any software help
    a_loader_boot: assert property (!$past(arst_n) |=> loader_start)
        else $error("no loader start");
    a_loader_once: assert property (loader_start |=> !loader_start)
        else $error("loader start too long");
    a_drive_set: assert property (sfr_wr && sfr_addr == 8'h93 |->
        ##2 port_a_drive_high == $past(sfr_wdata, 2)) else $error("drive strength lost");
    a_irq_clear: assert property ($fell(spi_irq) |->
        $past(sfr_rd) || $past(sfr_rd, 2) || $past(sfr_rd, 3)) else $error("irq fell unread");
    c_irq: cover property (spi_irq);
    c_loader: cover property (loader_start);
    c_pop: cover property (sfr_rd && sfr_addr == 8'hB2);
endmodule : spmpm_monitor
bind spmpm_top spmpm_monitor u_monitor (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .port_a_drive_high(port_a_drive_high), .boot_memory_select(boot_memory_select),
    .loader_start(loader_start), .spi_irq(spi_irq));
`default_nettype wire

// >>> test/spmpm_slave.sv
// Pin-side serial slave: mode 0, MSB first, answers a fixed byte.
// Assumes an active-low select and a clock idle low between bytes.
`timescale 1ns/1ps
`default_nettype none
module spmpm_slave #(parameter logic [7:0] REPLY = 8'hA5) (
    input wire logic sck,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sr = REPLY;
    // Deselected line shows the inverse so a stale bit cannot pass
    assign miso = cs_n ? ~sr[7] : sr[7];
    initial got = 8'h00;
    always @(posedge sck) if (!cs_n) got <= {got[6:0], mosi};
    always @(negedge sck) if (!cs_n) sr <= {sr[6:0], sr[7]};
endmodule : spmpm_slave
`default_nettype wire

// >>> test/spmpm_tb.sv
// Self-checking bench for spmpm_top: pin slave, radio loopback, port loopback.
// Assumes the slave model and the monitor are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic clk = 1'b0, link_clk = 1'b0, arst_n = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic radio_miso = 1'b0, boot_memory_select, radio_sck, radio_mosi, loader_start;
    logic spi_irq, miso;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, port_a_in = 8'h00, port_a_alt_in = 8'h3C;
    logic [7:0] sfr_rdata, port_a_out, port_a_oe, port_a_drive_high, port_a_pin_level;
    logic [7:0] radio_select, d, got;
    logic [3:0] serial_pin_in = 4'h0, serial_pin_out, serial_pin_oe;
    int num_errors = 0;
    int checks = 0;
    spmpm_top dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
        .port_a_drive_high(port_a_drive_high), .port_a_alt_in(port_a_alt_in),
        .port_a_pin_level(port_a_pin_level), .serial_pin_in(serial_pin_in),
        .serial_pin_out(serial_pin_out), .serial_pin_oe(serial_pin_oe),
        .boot_memory_select(boot_memory_select), .radio_select(radio_select),
        .radio_sck(radio_sck), .radio_mosi(radio_mosi), .radio_miso(radio_miso),
        .loader_start(loader_start), .spi_irq(spi_irq));
    spmpm_slave slave (.sck(serial_pin_out[0]), .mosi(serial_pin_out[1]),
        .cs_n(boot_memory_select), .miso(miso), .got(got));
    initial forever #2.5 clk = ~clk;
    initial #7 forever #15 link_clk = ~link_clk;
    always @(negedge clk) begin
        radio_miso <= radio_mosi;
        port_a_in <= port_a_out;
        serial_pin_in <= {serial_pin_out[3], miso, serial_pin_out[1:0]};
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = w;
        sfr_rd = !w;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask : acc
    task automatic wait_idle();
        for (int n = 0; n < 1000; n++) begin
            acc(1'b0, 8'hB3, 8'h00);
            if (d[4] === 1'b0) return;
        end
        num_errors++;
        summarize();
    endtask : wait_idle
    task automatic summarize();
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic t_reset();
        acc(1'b0, 8'h97, 8'h00);
        `CHK(d, 8'h07)
        acc(1'b0, 8'h00, 8'h00);
        `CHK(d, 8'h00)
        `CHK({radio_select, boot_memory_select}, 9'h1FF)
    endtask : t_reset
    task automatic t_pins();
        logic [15:0] t[4] = '{16'hB300, 16'hB404, 16'hB23C, 16'hB2FF};
        // Last write lands while busy and must be dropped
        foreach (t[i]) acc(1'b1, t[i][15:8], t[i][7:0]);
        `CHK({serial_pin_oe, boot_memory_select}, 5'h06)
        wait_idle();
        `CHK(spi_irq, 1'b1)
        `CHK(got, 8'h3C)
        acc(1'b0, 8'hB2, 8'h00);
        `CHK(d, 8'hA5)
        repeat (3) @(negedge clk);
        `CHK(spi_irq, 1'b0)
    endtask : t_pins
    task automatic t_radio();
        logic [15:0] t[3] = '{16'hA05A, 16'hB303, 16'hB2C3};
        foreach (t[i]) acc(1'b1, t[i][15:8], t[i][7:0]);
        `CHK(radio_select, 8'h5A)
        wait_idle();
        acc(1'b0, 8'hB2, 8'h00);
        `CHK(d, 8'hC3)
        `CHK({got, boot_memory_select}, {8'h3C, 1'b1})
        acc(1'b1, 8'hB3, 8'h06);
        `CHK(radio_select, 8'hFF)
    endtask : t_radio
    task automatic t_gpio();
        logic [15:0] t[7] = '{16'h9700, 16'h960F, 16'h900A, 16'h94FF, 16'h80A5, 16'h950F,
            16'h9355};
        foreach (t[i]) acc(1'b1, t[i][15:8], t[i][7:0]);
        `CHK({serial_pin_oe, serial_pin_out}, 8'hFA)
        `CHK(port_a_out, 8'hAC)
        acc(1'b0, 8'h80, 8'h00);
        `CHK(d, 8'hAC)
        `CHK({port_a_oe, port_a_pin_level}, 16'hFFAC)
    endtask : t_gpio
    initial begin
        // A real falling edge clears the link side before its clock first ticks
        #1 arst_n = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_pins();
        t_radio();
        t_gpio();
        summarize();
    end
endmodule : testbench
`default_nettype wire
